// file: hlt_pkg.sv
`default_nettype none
package hlt_pkg;

  // Counter width and sync depth
  localparam int CW          = 8;
  localparam int SYNC_STAGES = 2;

  // Count constants
  localparam logic [CW-1:0] COUNT_ZERO = 8'h00;
  localparam logic [CW-1:0] COUNT_ONE  = 8'h01;

  // Mode codes
  localparam logic [4:0] MODE_HL_ANY   = 5'h03;
  localparam logic [4:0] MODE_HL_RISE  = 5'h04;
  localparam logic [4:0] MODE_HL_FALL  = 5'h05;
  localparam logic [4:0] MODE_LVL_LOW  = 5'h06;
  localparam logic [4:0] MODE_LVL_HIGH = 5'h07;
  localparam logic [4:0] MODE_OS_SW    = 5'h08;
  localparam logic [4:0] MODE_OS_RISE  = 5'h09;
  localparam logic [4:0] MODE_OS_FALL  = 5'h0a;
  localparam logic [4:0] MODE_OS_ANY   = 5'h0b;

  // Static configuration from the timer control
  typedef struct packed {
    logic [4:0]    mode;
    logic [CW-1:0] period;
    logic [CW-1:0] pulse_width;
  } timer_cfg_type;

  // Start gate of the edge one-shot modes
  typedef enum logic [1:0] {
    OS_IDLE  = 2'b00,
    OS_ARMED = 2'b01,
    OS_COUNT = 2'b10
  } os_state_type;

endpackage
`default_nettype wire

// file: level_sync.sv
`timescale 1ns/100ps
`default_nettype none
module level_sync
  import hlt_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
)(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Asynchronous level in, synced level out
  input  wire logic async_i,
  output logic      sync_o
);

  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  // Shift chain; only the last stage is visible
  always_comb
  begin
    chain_d = {chain_q[STAGES-2:0], async_i};
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chain_q <= '0;
    else
      chain_q <= chain_d;
  end

  assign sync_o = chain_q[STAGES-1];

endmodule
`default_nettype wire

// file: edge_detect.sv
`timescale 1ns/100ps
`default_nettype none
module edge_detect (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Synchronised level in
  input  wire logic level_i,
  // One-cycle edge pulses
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_q;
  logic prev_d;

  // Previous sample of the level
  always_comb
  begin
    prev_d = level_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d;
  end

  // Edges are combinational so the counter reacts without extra lag
  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule
`default_nettype wire

// file: hardware_limit_timer.sv
`timescale 1ns/100ps
`default_nettype none
module hardware_limit_timer
  import hlt_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  // Software control
  input  wire timer_cfg_type  cfg_i,
  input  wire logic           run_wr_i,
  input  wire logic           run_wdata_i,
  // External reset pin
  input  wire logic           external_reset_input_i,
  // Timer state
  output logic [CW-1:0]       count_value_o,
  output logic                run_o,
  output logic                postscaled_match_output_o,
  // Compare/PWM drive
  output logic                pulse_set_signal_o,
  output logic                pwm_o
);

  logic          ers_s;
  logic          ers_rise;
  logic          ers_fall;
  logic          hl_edge;
  logic          lvl_mode;
  logic          os_sw;
  logic          os_edge;
  logic          one_shot;
  logic          hl_hit;
  logic          os_hit;
  logic          hl_reset;
  logic          lvl_hold;
  logic          counting;
  logic          period_hit;
  logic          width_hit;
  logic          run_start;
  logic          pset;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          run_q;
  logic          run_d;
  logic          pwm_q;
  logic          pwm_d;
  logic          pset_q;
  logic          pset_d;
  logic          match_q;
  logic          match_d;
  os_state_type  os_state_q;
  os_state_type  os_state_d;

  // Pin synchroniser; its two stages give the restart latency
  level_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (external_reset_input_i),
    .sync_o  (ers_s)
  );

  // Edges of the synchronised reset level
  // Limitation: the chain clears low, so a pin already high at reset shows one
  // rise; it only matters if software sets run on one of the first two edges after reset
  edge_detect u_edge (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .level_i (ers_s),
    .rise_o  (ers_rise),
    .fall_o  (ers_fall)
  );

  // Mode decode
  always_comb
  begin
    hl_edge  = (cfg_i.mode == MODE_HL_ANY) || (cfg_i.mode == MODE_HL_RISE)
            || (cfg_i.mode == MODE_HL_FALL);
    lvl_mode = (cfg_i.mode == MODE_LVL_LOW) || (cfg_i.mode == MODE_LVL_HIGH);
    os_sw    = (cfg_i.mode == MODE_OS_SW);
    os_edge  = (cfg_i.mode == MODE_OS_RISE) || (cfg_i.mode == MODE_OS_FALL)
            || (cfg_i.mode == MODE_OS_ANY);
    one_shot = os_sw || os_edge;
  end

  // Qualifying edges per mode
  always_comb
  begin
    hl_hit = ((cfg_i.mode == MODE_HL_ANY) && (ers_rise || ers_fall))
          || ((cfg_i.mode == MODE_HL_RISE) && ers_rise)
          || ((cfg_i.mode == MODE_HL_FALL) && ers_fall);
    os_hit = ((cfg_i.mode == MODE_OS_RISE) && ers_rise)
          || ((cfg_i.mode == MODE_OS_FALL) && ers_fall)
          || ((cfg_i.mode == MODE_OS_ANY) && (ers_rise || ers_fall));
  end

  // Reset and enable terms of the counter
  always_comb
  begin
    // Input only acts while running, so a stopped timer keeps its count
    hl_reset = hl_edge && run_q && hl_hit;
    lvl_hold = lvl_mode && run_q
            && ((cfg_i.mode == MODE_LVL_LOW) ? !ers_s : ers_s);
    counting = run_q && !hl_reset && !lvl_hold
            && (!os_edge || (os_state_q == OS_COUNT));
    period_hit = counting && (count_q == cfg_i.period);
    width_hit  = counting && (count_q == cfg_i.pulse_width);
  end

  // Counter next value
  always_comb
  begin
    count_d = count_q;
    if (hl_reset || lvl_hold)
      count_d = COUNT_ZERO;
    else if (period_hit)
      count_d = COUNT_ZERO;
    else if (counting)
      count_d = count_q + COUNT_ONE;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= COUNT_ZERO;
    else
      count_q <= count_d;
  end

  // Run bit: hardware clears on one-shot match, software write wins
  always_comb
  begin
    run_d = run_q;
    if (one_shot && period_hit)
      run_d = 1'b0;
    if (run_wr_i)
      run_d = run_wdata_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_q <= 1'b0;
    else
      run_q <= run_d;
  end

  // Edge one-shot start gate; any halt drops back to idle
  always_comb
  begin
    os_state_d = os_state_q;
    if (!os_edge || !run_q || period_hit)
      os_state_d = OS_IDLE;
    else
    begin
      unique case (os_state_q)
        OS_IDLE:
        begin
          os_state_d = os_hit ? OS_COUNT : OS_ARMED;
        end
        OS_ARMED:
        begin
          if (os_hit)
            os_state_d = OS_COUNT;
        end
        OS_COUNT:
        begin
          os_state_d = OS_COUNT;
        end
        default:
        begin
          os_state_d = OS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      os_state_q <= OS_IDLE;
    else
      os_state_q <= os_state_d;
  end

  // Pulse set: counting from zero, or software start of one-shot
  // Only a start from zero raises the drive; a resume after the width
  // match must not, or the drive would never meet its width again
  always_comb
  begin
    run_start = os_sw && run_wr_i && run_wdata_i && !run_q
             && (count_q == COUNT_ZERO);
    pset = (counting && (count_q == COUNT_ZERO)) || run_start;
  end

  // PWM drive; stopped counter never reaches width, so it stretches
  always_comb
  begin
    pwm_d = pwm_q;
    if (width_hit)
      pwm_d = 1'b0;
    // Set wins when width is zero so a start is never lost
    if (pset)
      pwm_d = 1'b1;
    // Reset while high leaves pwm_q alone until the width match
  end

  // Registered strobes for the compare unit
  always_comb
  begin
    pset_d  = pset;
    match_d = period_hit;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pwm_q   <= 1'b0;
      pset_q  <= 1'b0;
      match_q <= 1'b0;
    end
    else
    begin
      pwm_q   <= pwm_d;
      pset_q  <= pset_d;
      match_q <= match_d;
    end
  end

  // Outputs
  assign count_value_o             = count_q;
  assign run_o                     = run_q;
  assign pwm_o                     = pwm_q;
  assign pulse_set_signal_o        = pset_q;
  assign postscaled_match_output_o = match_q;

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_hl_edge_clear: assert property (
    hl_edge && run_q && hl_hit |=> count_q == COUNT_ZERO)
    else $error("edge limit did not clear counter");

  a_hl_restart_pulse: assert property (
    hl_reset && !run_wr_i ##1 !hl_reset
    |-> pset ##1 (pset_q && pwm_q))
    else $error("edge limit reset did not restart pulse");

  a_lvl_hold_zero: assert property (
    lvl_mode && run_q && ((cfg_i.mode == MODE_LVL_LOW) ? !ers_s : ers_s)
    |=> count_q == COUNT_ZERO)
    else $error("level reset did not hold counter");

  a_lvl_run_off: assert property (
    lvl_mode && !run_q |=> count_q == $past(count_q))
    else $error("counter moved while run clear");

  a_pin_two_flops: assert property (
    $rose(ers_s) |-> $past(external_reset_input_i, 2))
    else $error("reset pin reached logic too early");

  a_os_run_clear: assert property (
    one_shot && period_hit && !run_wr_i |=> !run_q && count_q == COUNT_ZERO)
    else $error("one-shot match did not stop timer");

  a_os_stays_off: assert property (
    one_shot && !run_q && !run_wr_i |=> !run_q && count_q == $past(count_q))
    else $error("one-shot restarted without software");

  a_sw_pwm_start: assert property (
    run_start |=> pwm_q && run_q)
    else $error("pwm did not start with run bit");

  a_pwm_width_end: assert property (
    width_hit && !pset |=> !pwm_q)
    else $error("pwm did not end at width match");

  a_pwm_stretch: assert property (
    pwm_q && !counting |=> pwm_q)
    else $error("pwm dropped while counter stopped");

  a_os_edge_wait: assert property (
    os_edge && os_state_q == OS_ARMED && !os_hit |=> count_q == $past(count_q))
    else $error("edge one-shot counted without edge");

  a_free_wrap: assert property (
    !one_shot && period_hit ##1 counting && cfg_i.period != COUNT_ZERO
    |-> count_q == COUNT_ZERO ##1 count_q == COUNT_ONE)
    else $error("free-run did not wrap and resume");

  a_count_gate: assert property (
    !counting && !hl_reset && !lvl_hold |=> count_q == $past(count_q))
    else $error("counter moved while disabled");

  a_sw_resume_quiet: assert property (
    os_sw && run_wr_i && run_wdata_i && !run_q && count_q != COUNT_ZERO
    |=> pwm_q == $past(pwm_q))
    else $error("one-shot resume changed the drive");

  a_pwm_set_high: assert property (
    pset |=> pwm_q && pset_q)
    else $error("pulse set did not raise pwm");

  a_lvl_count_start: assert property (
    lvl_mode && run_q && $fell(lvl_hold) && cfg_i.period != COUNT_ZERO
    |=> count_q == COUNT_ONE && pwm_q)
    else $error("level release did not start count and pwm");

  a_os_match_idle: assert property (
    os_edge && period_hit |=> os_state_q == OS_IDLE)
    else $error("edge one-shot did not need a fresh edge");

  a_match_strobe: assert property (
    period_hit |=> match_q)
    else $error("period match strobe missing");

  c_hl_restart: cover property (hl_reset ##2 pset_q);
  c_hl_early: cover property (hl_edge && hl_reset && count_q != COUNT_ZERO);
  c_lvl_release: cover property (lvl_mode && $fell(lvl_hold) && run_q);
  c_sw_pause: cover property (os_sw && run_q ##1 !run_q ##[1:8] run_q);
  c_os_edge_done: cover property (os_edge && period_hit);

endmodule
`default_nettype wire

// file: ers_src.sv
`timescale 1ns/100ps
`default_nettype none
// External reset pin source, moved only on bench command
module ers_src (
  // Pin toward the timer
  output logic pin_o
);
  // Idle low until the first reset sets a level
  initial pin_o = 1'b0;

  // Bench calls this right after a rising edge
  task automatic drive(input logic v);
    pin_o <= v;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hlt_pkg::*;

  // Stimulus and observed nets
  logic          mclk_i  = 1'b0;
  logic          rst_n_i = 1'b0;
  timer_cfg_type cfg     = '0;
  logic          run_wr  = 1'b0;
  logic          run_wd  = 1'b0;
  wire logic     pin;
  logic [CW-1:0] cnt;
  logic          run;
  logic          pm;
  logic          pset;
  logic          pwm;
  int            failures = 0;
  int            n_tests  = 0;

  // 40 MHz timer clock
  always #12.5 mclk_i = ~mclk_i;

  ers_src u_src (.pin_o(pin));

  hardware_limit_timer u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .run_wr_i(run_wr), .run_wdata_i(run_wd),
    .external_reset_input_i(pin), .count_value_o(cnt), .run_o(run),
    .postscaled_match_output_o(pm), .pulse_set_signal_o(pset), .pwm_o(pwm));

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction

  // Sample 1 ns after the edge so its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait: 0 count, 1 pwm, 2 run; running out ends the run
  task automatic wt(input int sel, input logic [7:0] v);
    int i;
    for (i = 0; i < 40; i++)
    begin
      cyc(1);
      if ((sel == 0 ? cnt : sel == 1 ? b(pwm) : b(run)) === v)
        return;
    end
    failures++;
    final_report();
  endtask

  // Config and pin level are set under reset, so each scenario starts clean
  task automatic start(input logic [4:0] m, input logic [7:0] p, input logic [7:0] w, input logic lv);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    cfg     <= '{mode: m, period: p, pulse_width: w};
    u_src.drive(lv);
    cyc(5);
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cyc(1);
  endtask

  // One-cycle write strobe; returns at the taking edge
  task automatic set_run(input logic v);
    @(posedge mclk_i);
    run_wr <= 1'b1;
    run_wd <= v;
    @(posedge mclk_i);
    run_wr <= 1'b0;
  endtask

  task automatic t_sw_oneshot();
    start(MODE_OS_SW, 8'h05, 8'h02, 1'b0);
    set_run(1'b1);
    #1;
    chk("pwm", 8'h01, b(pwm));
    chk("pset", 8'h01, b(pset));
    cyc(5);
    chk("count", 8'h05, cnt);
    cyc(1);
    chk("count", 8'h00, cnt);
    chk("run", 8'h00, b(run));
    chk("match", 8'h01, b(pm));
    chk("pwm", 8'h00, b(pwm));
    cyc(4);
    chk("count", 8'h00, cnt);
    // Pause after the width match; the resume must not raise the drive again
    set_run(1'b1);
    cyc(3);
    chk("pwm", 8'h00, b(pwm));
    set_run(1'b0);
    cyc(3);
    chk("count", 8'h05, cnt);
    chk("pwm", 8'h00, b(pwm));
    set_run(1'b1);
    #1;
    chk("pwm", 8'h00, b(pwm));
    cyc(1);
    chk("count", 8'h00, cnt);
    chk("run", 8'h00, b(run));
  endtask

  task automatic t_edge_limit();
    logic [4:0] md [3] = '{MODE_HL_ANY, MODE_HL_RISE, MODE_HL_FALL};
    int         k;
    for (k = 0; k < 3; k++)
    begin
      start(md[k], 8'h08, 8'h02, k == 2);
      set_run(1'b1);
      wt(0, 8'h08);
      cyc(1);
      chk("count", 8'h00, cnt);
      cyc(2);
      chk("count", 8'h02, cnt);
      @(posedge mclk_i);
      u_src.drive(k != 2);
      cyc(3);
      chk("count", 8'h00, cnt);
      chk("pwm", 8'h00, b(pwm));
      cyc(1);
      chk("pset", 8'h01, b(pset));
      chk("pwm", 8'h01, b(pwm));
    end
  endtask

  task automatic t_level();
    start(MODE_LVL_HIGH, 8'h0f, 8'h07, 1'b1);
    set_run(1'b1);
    cyc(6);
    chk("count", 8'h00, cnt);
    @(posedge mclk_i);
    u_src.drive(1'b0);
    cyc(2);
    chk("count", 8'h00, cnt);
    wt(0, 8'h01);
    chk("pwm", 8'h01, b(pwm));
    @(posedge mclk_i);
    u_src.drive(1'b1);
    cyc(6);
    chk("count", 8'h00, cnt);
    chk("pwm", 8'h01, b(pwm));
    @(posedge mclk_i);
    u_src.drive(1'b0);
    wt(0, 8'h07);
    chk("pwm", 8'h01, b(pwm));
    cyc(1);
    chk("pwm", 8'h00, b(pwm));
    set_run(1'b0);
    u_src.drive(1'b1);
    cyc(6);
    chk("count", 8'h0a, cnt);
  endtask

  task automatic t_edge_os();
    logic [4:0] md [3] = '{MODE_OS_RISE, MODE_OS_FALL, MODE_OS_ANY};
    int         k;
    for (k = 0; k < 3; k++)
    begin
      start(md[k], 8'h05, 8'h02, k == 1);
      set_run(1'b1);
      cyc(6);
      chk("count", 8'h00, cnt);
      @(posedge mclk_i);
      u_src.drive(k != 1);
      wt(1, 8'h01);
      wt(2, 8'h00);
      chk("pwm", 8'h00, b(pwm));
      chk("count", 8'h00, cnt);
      set_run(1'b1);
      cyc(6);
      chk("count", 8'h00, cnt);
    end
  endtask

  // Main sequence
  initial
  begin
    t_sw_oneshot();
    t_edge_limit();
    t_level();
    t_edge_os();
    final_report();
  end
endmodule
`default_nettype wire
